// ==== tw_defines.svh ====
// Register offsets, field positions, reset values and timing figures
// for the two-wire master/target port. Definitions only.
`ifndef TW_DEFINES_SVH
`define TW_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses on the register port)
`define TW_OFF_CLK_DIV      8'h00
`define TW_OFF_OWN_ADDR     8'h01
`define TW_OFF_MST_STATUS   8'h02
`define TW_OFF_PORT_CTRL    8'h03
`define TW_OFF_FIRST_BUF    8'h04
`define TW_OFF_SECOND_BUF   8'h05
`define TW_OFF_SHARED_BUF   8'h06
`define TW_OFF_LAUNCH       8'h07
`define TW_OFF_MAP_INDEX    8'h08
`define TW_OFF_MAP_DATA     8'h09
`define TW_OFF_LAST_POS     8'hE0
`define TW_OFF_BASE_LOW     8'hE1
`define TW_OFF_BASE_MID     8'hE2
`define TW_OFF_BASE_HIGH    8'hE3
`define TW_OFF_HOST_FLAGS   8'hE4

// ============================================================
// Reset values
`define TW_RST_CLK_DIV      8'h1F
`define TW_RST_OWN_ADDR     8'h5C
`define TW_RST_PORT_CTRL    8'h01
`define TW_RST_FIRST_BUF    8'h5A
`define TW_RST_SECOND_BUF   8'hF1
`define TW_RST_SHARED_BUF   8'h00
`define TW_RST_BASE_LOW     8'h80
`define TW_RST_BASE_MID     8'hD7
`define TW_RST_BASE_HIGH    8'h00

// ============================================================
// Field positions
`define TW_ST_BYTE_BUSY     0
`define TW_ST_PKT_BUSY      1
`define TW_ST_NACK          2
`define TW_CT_AUTO_INC      0
`define TW_CT_MASTER        1
`define TW_CT_MAP_MODE      2
`define TW_CT_STRETCH       3
`define TW_LN_ID            0
`define TW_LN_FIRST         1
`define TW_LN_WRITE         2
`define TW_LN_READ          3
`define TW_LN_START         4
`define TW_LN_STOP          5
`define TW_LN_RD_DIR        6
`define TW_LN_ACK_EN        7
`define TW_HF_ACCESS        0
`define TW_HF_READ          1

// ============================================================
// Timing: quarter bit periods per bus clock, bits per byte slot
`define TW_QUARTERS         4
`define TW_BITS_PER_SLOT    4'd8
`define TW_MIN_CLK_RATIO    10

`endif

// ==== tw_far_target.sv ====
// Behavioural far-side target for the two-wire port.
// Assumes both lines are pulled up outside; it never clocks.
`timescale 1ns/10ps
module tw_far_target #(
  parameter logic [6:0] ADDR = 7'h2E,
  parameter logic [7:0] RD_BYTE = 8'hA5
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_drv,
  output int nb,
  output logic [7:0] last
);
  logic act = 1'b0;
  logic rd = 1'b0;
  logic hit = 1'b0;
  int cnt = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_drv = 1'b1;
    nb = 0;
    last = 8'h00;
  end
  // ============================================================
  // Framing: data edges while the clock is high
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      cnt = 0;
      nb = 0;
      hit = 1'b0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
      sda_drv = 1'b1;
    end
  end
  // Sample on clock rise, MSB first; address decides ack
  always @(posedge scl) begin
    if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      if (cnt == 7) begin
        last = sh;
        if (nb == 0) begin
          hit = sh[7:1] == ADDR;
          rd = sh[0];
        end
      end
      if (cnt == 8) begin
        cnt = 0;
        nb++;
      end else cnt++;
    end
  end
  // Drive only while the clock is low; a stranger gets no ack
  always @(negedge scl) begin
    if (act && cnt == 8) sda_drv = !(hit && !(rd && nb == 1));
    else if (act && hit && rd && nb == 1) sda_drv = RD_BYTE[7 - cnt];
    else sda_drv = 1'b1;
  end
endmodule

// ==== tw_pkg.sv ====
// Types shared by the two-wire port and its surroundings.
// Assumes tw_defines.svh carries the numeric constants.
package tw_pkg;

  // ============================================================
  // Register port request, one strobe at a time
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tw_bus_req_t;

  // ============================================================
  // Open-drain pin drive: out is always low, oe_n low pulls
  typedef struct packed {
    logic scl_out;
    logic scl_oe_n;
    logic sda_out;
    logic sda_oe_n;
  } tw_pins_t;

  // Master engine states
  typedef enum logic [3:0] {
    TW_M_IDLE  = 4'b0001,
    TW_M_START = 4'b0010,
    TW_M_BYTE  = 4'b0100,
    TW_M_STOP  = 4'b1000
  } tw_mst_state_t;

  // Target engine states
  typedef enum logic [6:0] {
    TW_T_IDLE = 7'b0000001,
    TW_T_ADDR = 7'b0000010,
    TW_T_AACK = 7'b0000100,
    TW_T_RX   = 7'b0001000,
    TW_T_DACK = 7'b0010000,
    TW_T_TX   = 7'b0100000,
    TW_T_MACK = 7'b1000000
  } tw_tgt_state_t;

endpackage

// ==== tw_port.sv ====
// Two-wire bus controller: master engine with launch register and
// target engine with a 128-byte mapping buffer.
// Assumes clk runs at least ten times the bus bit rate and that the
// board pulls both lines up; pins are open drain.
//
// What this block does
// RULE_01: Runs 100k or 400k bit rates when clk is at least ten times faster.
// RULE_02: Both lines are released high whenever no transfer is running.
// RULE_03: Data line changes only while the clock line is low.
// RULE_04: Only the master starts transfers and clocks; the target never clocks.
// RULE_05: Own/target address sits in bits 7..1 at 0x01, reset 0x5c.
// RULE_06: Clock speed register at 0x00 resets to 0x1f.
// RULE_07: Master bus clock is clk divided by four times the speed value.
// RULE_08: Status 0x02 shows byte busy bit 0, packet busy bit 1.
// RULE_09: Packet busy from start to stop; byte busy during each cycle.
// RULE_10: Status bit 2 captures target answer: 0 ack, 1 nack.
// RULE_11: Control 0x03 bit 0 enables address increment; resets to 0x01.
// RULE_12: Control bit 1 selects master mode, clear means target.
// RULE_13: Control bit 2 selects mapping mode for target accesses.
// RULE_14: Target writes fill buffer bytes 0..63, reads come from 64..127.
// RULE_15: With control bit 3 set, a held-low clock pauses the transfer.
// RULE_16: Buffers at 0x04, 0x05, 0x06 reset to 0x5a, 0xf1, 0x00.
// RULE_17: Launch bits: 0 address cycle, 1 first byte, 2 write, 3 read.
// RULE_18: Launch bit 3 adds third write byte; reads always set bit 3.
// RULE_19: Launch bit 4 requests start, bit 5 requests stop.
// RULE_20: Launch bit 6 reads direction; bit 7 acks each received byte.
// RULE_21: Enabled cycles run in order: start, address, data, stop.
// RULE_22: Register 0xe0 reports last mapping position, bits 6..0, reset 0.
// RULE_23: Base address bytes 0xe1..0xe3 reset to 0x80, 0xd7, 0x00.
// RULE_24: Flag 0xe4 bit 0 sets on host access; write 1 clears.
// RULE_25: Flag 0xe4 bit 1 sets on host read access; write 1 clears.
// RULE_26: Reset restores defaults, abandons transfers, releases both lines.
// RULE_27: After a nack the master still runs the enabled stop cycle.
`timescale 1ns/10ps
`include "tw_defines.svh"

module tw_port (
  input wire logic clk,
  input wire logic resetn,
  input wire tw_pkg::tw_bus_req_t bus_req,
  output logic [7:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  output tw_pkg::tw_pins_t pins,
  output logic [23:0] map_base
);
  import tw_pkg::*;

  // ============================================================
  // Registers
  logic [7:0] clk_div;
  logic [7:0] own_addr;
  logic [7:0] port_ctrl;
  logic [7:0] first_buf;
  logic [7:0] second_buf;
  logic [7:0] shared_buf;
  logic [7:0] launch;
  logic [6:0] map_index;
  logic [6:0] last_pos;
  logic [7:0] base_low;
  logic [7:0] base_mid;
  logic [7:0] base_high;
  logic [1:0] host_flags;
  logic byte_busy;
  logic pkt_busy;
  logic nack_seen;
  logic [7:0] map_mem [0:127];

  // ============================================================
  // Pin synchronisers; first stage feeds only the second
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;

  // Two stages before use, third stage only for edge detection
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'b111;
      {sda_s1, sda_s2, sda_s3} <= 3'b111;
    end else begin
      {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
    end
  end

  // Bus events seen by the target; needs clk >= 10x bit rate RULE_01
  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_ev = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_ev = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ============================================================
  // Register port decode
  wire wr = bus_req.wr;
  wire [7:0] wd = bus_req.wdata;
  wire [7:0] ad = bus_req.addr;
  wire master_en = port_ctrl[`TW_CT_MASTER]; // RULE_12
  wire auto_inc = port_ctrl[`TW_CT_AUTO_INC]; // RULE_11
  wire map_en = port_ctrl[`TW_CT_MAP_MODE]; // RULE_13
  wire stretch_en = port_ctrl[`TW_CT_STRETCH];
  wire [7:0] status = {5'h00, nack_seen, pkt_busy, byte_busy}; // RULE_08
  wire [7:0] rd_mux =
    (ad == `TW_OFF_CLK_DIV) ? clk_div :
    (ad == `TW_OFF_OWN_ADDR) ? own_addr :
    (ad == `TW_OFF_MST_STATUS) ? status :
    (ad == `TW_OFF_PORT_CTRL) ? port_ctrl :
    (ad == `TW_OFF_FIRST_BUF) ? first_buf :
    (ad == `TW_OFF_SECOND_BUF) ? second_buf :
    (ad == `TW_OFF_SHARED_BUF) ? shared_buf :
    (ad == `TW_OFF_LAUNCH) ? launch :
    (ad == `TW_OFF_MAP_INDEX) ? {1'b0, map_index} :
    (ad == `TW_OFF_MAP_DATA) ? map_mem[map_index] :
    (ad == `TW_OFF_LAST_POS) ? {1'b0, last_pos} : // RULE_22
    (ad == `TW_OFF_BASE_LOW) ? base_low :
    (ad == `TW_OFF_BASE_MID) ? base_mid :
    (ad == `TW_OFF_BASE_HIGH) ? base_high :
    (ad == `TW_OFF_HOST_FLAGS) ? {6'h00, host_flags} : 8'h00;
  assign map_base = {base_high, base_mid, base_low};

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rdata <= 8'h00;
    else rdata <= bus_req.rd ? rd_mux : 8'h00;
  end

  // Plain configuration registers RULE_26
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clk_div <= `TW_RST_CLK_DIV; // RULE_06
      own_addr <= `TW_RST_OWN_ADDR; // RULE_05
      port_ctrl <= `TW_RST_PORT_CTRL; // RULE_11
      first_buf <= `TW_RST_FIRST_BUF; // RULE_16
      second_buf <= `TW_RST_SECOND_BUF; // RULE_16
      map_index <= 7'h00;
      base_low <= `TW_RST_BASE_LOW; // RULE_23
      base_mid <= `TW_RST_BASE_MID; // RULE_23
      base_high <= `TW_RST_BASE_HIGH; // RULE_23
    end else if (wr) begin
      if (ad == `TW_OFF_CLK_DIV) clk_div <= wd;
      else if (ad == `TW_OFF_OWN_ADDR) own_addr <= wd;
      else if (ad == `TW_OFF_PORT_CTRL) port_ctrl <= wd;
      else if (ad == `TW_OFF_FIRST_BUF) first_buf <= wd;
      else if (ad == `TW_OFF_SECOND_BUF) second_buf <= wd;
      else if (ad == `TW_OFF_MAP_INDEX) map_index <= wd[6:0];
      else if (ad == `TW_OFF_BASE_LOW) base_low <= wd;
      else if (ad == `TW_OFF_BASE_MID) base_mid <= wd;
      else if (ad == `TW_OFF_BASE_HIGH) base_high <= wd;
    end
  end

  // ============================================================
  // Master engine
  tw_mst_state_t m_state;
  logic [7:0] q_cnt;
  logic [1:0] q_ph;
  logic [3:0] m_bit;
  logic [7:0] m_sh;
  logic m_rd_byte;
  logic m_scl_low, m_sda_low;

  // Next cycle in bus order: start, address, data, stop RULE_21
  wire ln_rd = launch[`TW_LN_RD_DIR]; // RULE_20
  wire go_start = launch[`TW_LN_START]; // RULE_19
  wire go_id = launch[`TW_LN_ID]; // RULE_17
  wire go_first = launch[`TW_LN_FIRST];
  wire go_write = launch[`TW_LN_WRITE] & ~ln_rd;
  wire go_third = launch[`TW_LN_READ] & ~ln_rd; // RULE_18
  wire go_read = launch[`TW_LN_READ] & ln_rd;
  wire go_stop = launch[`TW_LN_STOP];
  wire go_byte = go_id | go_first | go_write | go_third | go_read;
  wire [7:0] byte_src =
    go_id ? {own_addr[7:1], ln_rd} :
    go_first ? first_buf :
    go_write ? second_buf : shared_buf;
  wire [7:0] done_mask =
    go_id ? 8'h01 : go_first ? 8'h02 : go_write ? 8'h04 : 8'h08;

  // Quarter-period ticks: divider 0 is treated as 1 RULE_07
  wire [7:0] div_eff = (clk_div == 8'h00) ? 8'h01 : clk_div;
  // Released clock still seen low means the far side is pausing
  wire held = stretch_en & ~m_scl_low & ~scl_s2 & q_ph[1]; // RULE_15
  wire q_tick = (q_cnt == div_eff - 8'h01) & ~held;
  wire m_run = (m_state != TW_M_IDLE);
  wire m_last = q_tick & (q_ph == 2'd3);

  // Quarter counter runs only while a cycle is on the bus
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_cnt <= 8'h00;
      q_ph <= 2'd0;
    end else if (!m_run || held) begin
      q_cnt <= 8'h00;
      q_ph <= m_run ? q_ph : 2'd0;
    end else if (q_tick) begin
      q_cnt <= 8'h00;
      q_ph <= q_ph + 2'd1;
    end else begin
      q_cnt <= q_cnt + 8'h01;
    end
  end

  // Master sequencing, line drive and launch bookkeeping
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      m_state <= TW_M_IDLE;
      m_bit <= 4'd0;
      m_sh <= 8'h00;
      m_rd_byte <= 1'b0;
      m_scl_low <= 1'b0; // RULE_02
      m_sda_low <= 1'b0; // RULE_26
      launch <= 8'h00;
      pkt_busy <= 1'b0;
      nack_seen <= 1'b0;
      shared_buf <= `TW_RST_SHARED_BUF; // RULE_16
    end else begin
      if (wr && ad == `TW_OFF_SHARED_BUF && !m_run) shared_buf <= wd;
      if (wr && ad == `TW_OFF_LAUNCH && !m_run && !master_en)
        launch <= 8'h00;
      else if (wr && ad == `TW_OFF_LAUNCH && !m_run && launch[5:0] == 6'h00)
        launch <= wd;
      case (m_state)
        TW_M_IDLE: begin
          if (master_en && go_start) begin
            m_state <= TW_M_START;
          end else if (master_en && go_byte) begin
            m_state <= TW_M_BYTE;
            m_sh <= byte_src;
            m_rd_byte <= go_read & ~go_id & ~go_first;
            m_bit <= 4'd0;
          end else if (master_en && go_stop) begin
            m_state <= TW_M_STOP;
          end
        end
        TW_M_START: begin
          if (q_tick && q_ph == 2'd2) m_sda_low <= 1'b1; // RULE_03
          if (m_last) begin
            m_scl_low <= 1'b1; // RULE_04
            pkt_busy <= 1'b1; // RULE_09
            launch[`TW_LN_START] <= 1'b0;
            m_state <= TW_M_IDLE;
          end
        end
        TW_M_BYTE: begin
          // Data set up in the first quarter, clock still low RULE_03
          if (q_tick && q_ph == 2'd0) begin
            if (m_bit == `TW_BITS_PER_SLOT)
              m_sda_low <= m_rd_byte & launch[`TW_LN_ACK_EN]; // RULE_20
            else
              m_sda_low <= ~m_rd_byte & ~m_sh[7];
          end
          if (q_tick && q_ph == 2'd1) m_scl_low <= 1'b0;
          if (m_last) begin
            m_scl_low <= 1'b1;
            m_bit <= m_bit + 4'd1;
            if (m_bit != `TW_BITS_PER_SLOT) begin
              m_sh <= {m_sh[6:0], sda_s2};
            end else begin
              m_state <= TW_M_IDLE;
              launch <= launch & ~done_mask;
              if (m_rd_byte) begin
                shared_buf <= m_sh;
              end else begin
                nack_seen <= sda_s2; // RULE_10
                // Drop further data, keep the stop RULE_27
                if (sda_s2) launch[3:0] <= 4'h0;
              end
            end
          end
        end
        TW_M_STOP: begin
          if (q_tick && q_ph == 2'd0) m_sda_low <= 1'b1;
          if (q_tick && q_ph == 2'd1) m_scl_low <= 1'b0;
          if (m_last) begin
            m_sda_low <= 1'b0; // RULE_02
            pkt_busy <= 1'b0; // RULE_09
            launch[`TW_LN_STOP] <= 1'b0;
            m_state <= TW_M_IDLE;
          end
        end
        default: m_state <= TW_M_IDLE;
      endcase
    end
  end
  assign byte_busy = m_run; // RULE_09

  // ============================================================
  // Target engine
  tw_tgt_state_t t_state;
  logic [3:0] t_cnt;
  logic [7:0] t_sh;
  logic [5:0] t_ptr;
  logic [6:0] t_last;
  logic t_hit, t_rw;
  logic t_sda_low;
  logic t_wr;

  // Writes land low, reads come from the upper half RULE_14
  wire [6:0] t_rd_idx = {1'b1, t_ptr};
  wire [7:0] t_rd_byte = map_en ? map_mem[t_rd_idx] : 8'hFF;
  wire [5:0] t_ptr_inc = auto_inc ? t_ptr + 6'd1 : t_ptr;
  wire t_addr_ok = (t_sh[7:1] == own_addr[7:1]); // RULE_05
  // The target never pulls the clock line RULE_04
  wire t_on = ~master_en;

  // Host access flags: a new access wins over a clearing write
  wire flag_set = t_on & stop_ev & t_hit;
  wire [1:0] flag_clr = (wr && ad == `TW_OFF_HOST_FLAGS) ? wd[1:0] : 2'b00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      host_flags <= 2'b00;
      last_pos <= 7'h00; // RULE_22
    end else begin
      host_flags[`TW_HF_ACCESS] <= flag_set |
        (host_flags[`TW_HF_ACCESS] & ~flag_clr[`TW_HF_ACCESS]); // RULE_24
      host_flags[`TW_HF_READ] <= (flag_set & t_rw) |
        (host_flags[`TW_HF_READ] & ~flag_clr[`TW_HF_READ]); // RULE_25
      if (flag_set) last_pos <= t_last;
    end
  end

  // Target bit engine; data line moves on clock falls only RULE_03
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t_state <= TW_T_IDLE;
      t_cnt <= 4'd0;
      t_sh <= 8'h00;
      t_ptr <= 6'd0;
      t_last <= 7'h00;
      t_hit <= 1'b0;
      t_rw <= 1'b0;
      t_sda_low <= 1'b0;
      t_wr <= 1'b0;
    end else begin
      t_wr <= 1'b0;
      if (!t_on || stop_ev) begin
        t_state <= TW_T_IDLE;
        t_sda_low <= 1'b0;
        t_hit <= 1'b0;
        t_ptr <= 6'd0;
      end else if (start_ev) begin
        t_state <= TW_T_ADDR;
        t_cnt <= 4'd0;
        t_sda_low <= 1'b0;
      end else begin
        case (t_state)
          TW_T_ADDR, TW_T_RX: begin
            if (scl_rise && t_cnt != `TW_BITS_PER_SLOT) begin
              t_sh <= {t_sh[6:0], sda_s2};
              t_cnt <= t_cnt + 4'd1;
            end
            if (scl_fall && t_cnt == `TW_BITS_PER_SLOT) begin
              if (t_state == TW_T_RX) begin
                t_wr <= map_en;
                t_last <= {1'b0, t_ptr};
                t_ptr <= t_ptr_inc;
                t_sda_low <= 1'b1;
                t_state <= TW_T_DACK;
              end else if (t_addr_ok) begin
                t_hit <= 1'b1;
                t_rw <= t_sh[0];
                t_sda_low <= 1'b1;
                t_state <= TW_T_AACK;
              end else begin
                t_state <= TW_T_IDLE;
              end
            end
          end
          TW_T_AACK, TW_T_DACK: begin
            if (scl_fall) begin
              t_cnt <= 4'd0;
              if (t_rw) begin
                t_sh <= t_rd_byte;
                t_sda_low <= ~t_rd_byte[7];
                t_last <= t_rd_idx;
                t_ptr <= t_ptr_inc;
                t_state <= TW_T_TX;
              end else begin
                t_sda_low <= 1'b0;
                t_state <= TW_T_RX;
              end
            end
          end
          TW_T_TX: begin
            if (scl_rise) t_cnt <= t_cnt + 4'd1;
            if (scl_fall && t_cnt == `TW_BITS_PER_SLOT) begin
              t_sda_low <= 1'b0;
              t_state <= TW_T_MACK;
            end else if (scl_fall) begin
              t_sda_low <= ~t_sh[6];
              t_sh <= {t_sh[6:0], 1'b0};
            end
          end
          TW_T_MACK: begin
            // A nack ends the read; wait quietly for the stop
            if (scl_rise && sda_s2) t_state <= TW_T_IDLE;
            else if (scl_fall) t_state <= TW_T_DACK;
          end
          default: t_state <= TW_T_IDLE;
        endcase
      end
    end
  end

  // ============================================================
  // Mapping buffer: target write port has priority over software
  always_ff @(posedge clk) begin
    if (t_wr) map_mem[{1'b0, t_last[5:0]}] <= t_sh;
    else if (wr && ad == `TW_OFF_MAP_DATA) map_mem[map_index] <= wd;
  end

  // Open drain: lines only ever pulled low, else released RULE_02
  assign pins.scl_out = 1'b0;
  assign pins.sda_out = 1'b0;
  assign pins.scl_oe_n = ~m_scl_low;
  assign pins.sda_oe_n = ~(m_sda_low | t_sda_low);

endmodule

// ==== tw_port_monitor.sv ====
// Checker for the two-wire port, bound to its ports.
// Assumes registers change only through writes on bus_req.
`timescale 1ns/10ps
`include "tw_defines.svh"
module tw_port_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire tw_pkg::tw_bus_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire tw_pkg::tw_pins_t pins,
  input wire logic [23:0] map_base
);
  import tw_pkg::*;
  // ============================================================
  // Shadows of the settings the checks lean on
  logic [7:0] div_sh;
  logic [7:0] own_sh;
  logic [7:0] ctl_sh;
  logic [15:0] hcnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_sh <= `TW_RST_CLK_DIV;
      own_sh <= `TW_RST_OWN_ADDR;
      ctl_sh <= `TW_RST_PORT_CTRL;
    end else if (bus_req.wr) begin
      if (bus_req.addr == 8'h00) div_sh <= bus_req.wdata;
      if (bus_req.addr == 8'h01) own_sh <= bus_req.wdata;
      if (bus_req.addr == 8'h03) ctl_sh <= bus_req.wdata;
    end
  end
  // Cycles the clock line stayed released; saturates, never wraps
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hcnt <= 16'h0000;
    else if (!pins.scl_oe_n) hcnt <= 16'h0000;
    else if (hcnt != 16'hFFFF) hcnt <= hcnt + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ============================================================
  // Checks
  AST_OPEN_DRAIN: assert property (
    !pins.scl_out && !pins.sda_out) else $error("pin level not low");
  AST_RESET_FREE: assert property (
    $rose(resetn) |-> pins.scl_oe_n && pins.sda_oe_n)
    else $error("lines held after reset");
  AST_TGT_NO_CLK: assert property (
    !ctl_sh[1] |-> pins.scl_oe_n) else $error("target drove clock");
  AST_DIV_HIGH: assert property (
    $fell(pins.scl_oe_n) && ctl_sh[1] |-> hcnt >= {8'h00, div_sh})
    else $error("clock high phase too short");
  AST_DIV_READ: assert property (
    bus_req.rd && bus_req.addr == 8'h00 |=> rdata == $past(div_sh))
    else $error("divider readback wrong");
  AST_OWN_READ: assert property (
    bus_req.rd && bus_req.addr == 8'h01 |=> rdata == $past(own_sh))
    else $error("address readback wrong");
  AST_CTL_READ: assert property (
    bus_req.rd && bus_req.addr == 8'h03 |=> rdata == $past(ctl_sh))
    else $error("control readback wrong");
  AST_MAP_BASE: assert property (
    bus_req.wr && bus_req.addr == 8'hE1
    |=> map_base[7:0] == $past(bus_req.wdata))
    else $error("base low byte not exported");
endmodule

// ==== tw_port_tb.sv ====
// Self-checking bench for the two-wire port with a far-side target.
// Assumes the board pull-ups are modelled by the wired-AND below.
`timescale 1ns/10ps
module tw_port_tb;
  import tw_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  tw_bus_req_t bus_req = '0;
  logic [7:0] rdata;
  logic [23:0] map_base;
  tw_pins_t pins;
  logic sda_drv;
  int nb;
  logic [7:0] last;
  int failures = 0;
  int checks = 0;
  logic m_scl = 1'b1;
  logic m_sda = 1'b1;
  // Open-drain lines: anyone pulling low wins
  wire scl_w = pins.scl_oe_n & m_scl;
  wire sda_w = pins.sda_oe_n & sda_drv & m_sda;
  tw_port u_dut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
    .rdata(rdata), .scl_in(scl_w), .sda_in(sda_w), .pins(pins),
    .map_base(map_base));
  tw_far_target u_far (.scl(scl_w), .sda(sda_w), .sda_drv(sda_drv),
    .nb(nb), .last(last));
  initial begin
    forever #5 clk = ~clk;
  end
  // ============================================================
  // Shared bus cycles and compare
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk({16'h0000, d}, {16'h0000, e});
  endtask
  // Launch, poll status to idle, then judge what crossed the wire
  task automatic xfer(input logic [7:0] ln, input logic [7:0] st,
    input int n, input logic [7:0] lb);
    logic [7:0] s;
    logic [1:0] seen;
    seen = 2'b00;
    wr(8'h07, ln);
    for (int i = 0; i < 3000; i++) begin
      rd(8'h02, s);
      seen = seen | s[1:0];
      if (seen[1] && s[1:0] == 2'b00) break;
    end
    chk({22'h0, seen}, 24'h3);
    chk({16'h0000, s}, {16'h0000, st});
    chk(nb[23:0], n[23:0]);
    chk({16'h0000, last}, {16'h0000, lb});
    chk_rd(8'h07, ln & 8'hC0);
    chk({22'h0, scl_w, sda_w}, 24'h3);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset;
    logic [7:0] a[14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
      8'h06, 8'h07, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE4, 8'h10};
    logic [7:0] e[14] = '{8'h1F, 8'h5C, 8'h00, 8'h01, 8'h5A, 8'hF1,
      8'h00, 8'h00, 8'h00, 8'h80, 8'hD7, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 14; i++) chk_rd(a[i], e[i]);
    chk(map_base, 24'h00D780);
    $display("reset values done");
  endtask
  task automatic t_regs;
    logic [7:0] a[8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'hE1,
      8'hE0, 8'h10};
    logic [7:0] d[8] = '{8'h03, 8'h02, 8'h11, 8'h22, 8'hC3, 8'h34,
      8'h55, 8'h66};
    logic [7:0] e[8] = '{8'h03, 8'h02, 8'h11, 8'h22, 8'hC3, 8'h34,
      8'h00, 8'h00};
    for (int i = 0; i < 8; i++) wr(a[i], d[i]);
    for (int i = 0; i < 8; i++) chk_rd(a[i], e[i]);
    chk(map_base, 24'h00D734);
    $display("register access done");
  endtask
  task automatic t_write3;
    xfer(8'h3F, 8'h00, 4, 8'hC3);
    $display("three byte write done");
  endtask
  task automatic t_write2;
    xfer(8'h37, 8'h00, 3, 8'h22);
    $display("two byte write done");
  endtask
  task automatic t_read;
    xfer(8'hF9, 8'h00, 2, 8'hA5);
    chk_rd(8'h06, 8'hA5);
    $display("read done");
  endtask
  task automatic t_nack;
    wr(8'h01, 8'h40);
    xfer(8'h3F, 8'h04, 1, 8'h40);
    wr(8'h01, 8'h5C);
    $display("no ack done");
  endtask
  task automatic t_abort;
    logic [7:0] s;
    s = 8'h00;
    wr(8'h07, 8'h3F);
    for (int i = 0; i < 200 && !s[1]; i++) rd(8'h02, s);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    chk({22'h0, scl_w, sda_w}, 24'h3);
    resetn <= 1'b1;
    chk_rd(8'h00, 8'h1F);
    chk_rd(8'h07, 8'h00);
    chk_rd(8'h02, 8'h00);
    $display("abort done");
  endtask
  // Bench as far master: one bit, data set while clock low
  task automatic sbit(input logic b);
    m_sda <= b;
    repeat (8) @(posedge clk);
    m_scl <= 1'b1;
    repeat (8) @(posedge clk);
    m_scl <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_target;
    logic [26:0] v;
    v = {8'h5C, 1'b1, 8'h96, 1'b1, 8'h3C, 1'b1};
    wr(8'h03, 8'h05);
    m_sda <= 1'b0;
    repeat (8) @(posedge clk);
    m_scl <= 1'b0;
    for (int i = 26; i >= 0; i--) sbit(v[i]);
    m_sda <= 1'b0;
    repeat (8) @(posedge clk);
    m_scl <= 1'b1;
    repeat (8) @(posedge clk);
    m_sda <= 1'b1;
    repeat (8) @(posedge clk);
    chk_rd(8'hE4, 8'h01);
    chk_rd(8'hE0, 8'h01);
    wr(8'h08, 8'h01);
    chk_rd(8'h09, 8'h3C);
    wr(8'hE4, 8'h01);
    chk_rd(8'hE4, 8'h00);
    $display("target write done");
  endtask
  // ============================================================
  // Verdict, main sequence and watchdog
  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_regs();
    t_write3();
    t_write2();
    t_read();
    t_nack();
    t_abort();
    t_target();
    print_verdict();
  end
  // Transfers take a few hundred cycles; far above that means a hang
  initial begin
    #500000;
    failures++;
    print_verdict();
  end
endmodule
bind tw_port tw_port_monitor u_mon (.clk(clk), .resetn(resetn),
  .bus_req(bus_req), .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in),
  .pins(pins), .map_base(map_base));
